// file: rtl/ptimer_pkg.sv
// Constants, field layouts and carrier types of the periodic timer
package ptimer_pkg;

   // ----------------------------------------------------------------
   // Widths and limits
   // ----------------------------------------------------------------
   localparam int CNT_W = 10;                       // Counter and compare width
   localparam int CTRL_W = 11;                      // Control word width
   localparam logic [9:0] CNT_MAX = 10'h3FF;        // Top of the count range
   localparam logic [9:0] CNT_ZERO = 10'h000;       // Counter restart value
   localparam logic [9:0] CNT_ONE = 10'h001;        // Counter step

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;         // Timer control
   localparam logic [7:0] OFS_INSEL = 8'h04;        // Input select register
   localparam logic [7:0] OFS_CMP_CAP_A = 8'h08;    // Compare/capture A
   localparam logic [7:0] OFS_CMP_CAP_B = 8'h0C;    // Capture B
   localparam logic [7:0] OFS_PERIOD_CMP = 8'h10;   // Period compare
   localparam logic [7:0] OFS_COUNT = 8'h14;        // Live counter, read only
   localparam logic [7:0] OFS_STAT = 8'h18;         // Status, read only

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int INSEL_LSB = 6;                    // Source select low bit
   localparam int STAT_LEVEL_BIT = 0;               // Capture level flag
   localparam int STAT_OUT_BIT = 1;                 // Pulse output level
   localparam logic [1:0] INSEL_RST = 2'h0;         // Source select reset
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;     // Bus transfer code

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,                         // Not handled here
      MODE_CAPTURE = 2'b01,                         // Input capture
      MODE_PWM_PULSE = 2'b10,                       // Single pulse when function 11
      MODE_COUNTER = 2'b11                          // Not handled here
   } timer_mode_e;

   localparam logic [1:0] OFN_PULSE = 2'b11;        // Function code of single pulse
   localparam logic [1:0] EDGE_NONE = 2'b11;        // Capture edge select: none
   localparam logic [1:0] TCLR_NONE = 2'b00;        // Clear trigger: period only

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic capture_source_bit;                     // Bit 10
      logic [1:0] clear_trigger_field;              // Bits 9:8
      logic counter_run_bit;                        // Bit 7
      logic counter_clear_select;                   // Bit 6
      logic output_polarity;                        // Bit 5
      logic output_initial_state;                   // Bit 4
      logic [1:0] output_function_field;            // Bits 3:2
      timer_mode_e timer_mode_field;                // Bits 1:0
   } ctrl_s;

   localparam ctrl_s CTRL_RST = ctrl_s'(11'h000);   // Control reset value

   typedef struct packed {
      logic match_a;                                // Comparator A event
      logic match_p;                                // Comparator P event
      logic capture;                                // Capture event
   } timer_evt_s;

   typedef struct packed {
      logic [2:0] trig_sync;                        // Trigger pin synchroniser
      logic [2:0] cap_sync;                         // Capture source synchroniser
      ctrl_s ctrl;                                  // Control word
      logic [1:0] input_source_select;              // Capture pin choice
      logic [9:0] compare_capture_a;                // Compare/capture A
      logic [9:0] compare_capture_b;                // Capture B
      logic [9:0] period_compare;                   // Period compare
      logic [9:0] count;                            // Counter
      logic run_prev;                               // Run bit one cycle ago
      logic out_level;                              // Raw pulse level
      logic out_pin;                                // Level after polarity
      logic drive;                                  // Output enable
      logic capture_level_flag;                     // Level at last capture
      logic wr_pend;                                // Write data phase due
      logic [7:0] wr_addr;                          // Latched write offset
      logic [31:0] rdata;                           // Read data
      timer_evt_s evt;                              // Event pulses
   } state_s;

endpackage : ptimer_pkg

// file: rtl/periodic_timer_pulse_capture.sv
// Periodic timer single-pulse and input-capture logic with AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps

module periodic_timer_pulse_capture (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Timer pins
   input wire logic external_trigger_pin,
   input wire logic [3:0] capture_input_pin,
   output logic timer_out,
   output logic timer_out_en,
   // Timer events towards the interrupt controller
   output ptimer_pkg::timer_evt_s timer_evt
);

   // ----------------------------------------------------------------
   // State and decoded conditions
   // ----------------------------------------------------------------
   ptimer_pkg::state_s s_reg;                       // All state
   ptimer_pkg::state_s s_next;                      // Next state
   logic bus_take;                                  // Address phase accepted
   logic cap_pin;                                   // Selected capture source
   logic sp_mode;                                   // Single pulse active
   logic cap_mode;                                  // Capture active
   logic run;                                       // Registered run bit
   logic run_rise;                                  // Run bit just rose
   logic trig_rise;                                 // Trigger pin rising edge
   logic cap_rise;                                  // Capture source rising
   logic cap_fall;                                  // Capture source falling
   logic cap_hit;                                   // Selected capture edge
   logic clr_hit;                                   // Selected clear edge
   logic [9:0] p_limit;                             // Period match value
   logic p_match;                                   // Comparator P match
   logic a_match;                                   // Comparator A match

   // Edge selection shared by capture and clear decoding
   function automatic logic edge_hit(input logic use_r, input logic use_f,
                                     input logic r, input logic f);
      edge_hit = (use_r & r) | (use_f & f);
   endfunction : edge_hit

   // Register read map, unmapped offsets read zero
   function automatic logic [31:0] read_word(input ptimer_pkg::state_s s,
                                             input logic [7:0] a);
      read_word = 32'h0000_0000;
      case (a)
         ptimer_pkg::OFS_CTRL: read_word = 32'(s.ctrl);
         ptimer_pkg::OFS_INSEL: read_word[ptimer_pkg::INSEL_LSB +: 2] = s.input_source_select;
         ptimer_pkg::OFS_CMP_CAP_A: read_word = 32'(s.compare_capture_a);
         ptimer_pkg::OFS_CMP_CAP_B: read_word = 32'(s.compare_capture_b);
         ptimer_pkg::OFS_PERIOD_CMP: read_word = 32'(s.period_compare);
         ptimer_pkg::OFS_COUNT: read_word = 32'(s.count);
         ptimer_pkg::OFS_STAT: begin
            read_word[ptimer_pkg::STAT_LEVEL_BIT] = s.capture_level_flag;
            read_word[ptimer_pkg::STAT_OUT_BIT] = s.out_level;
         end
         default: read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Transfer taken on any active transfer type; size is word only
   assign bus_take = hsel & hready & htrans[1];
   // Source mux ahead of the synchroniser, pins read in any direction
   assign cap_pin = s_reg.ctrl.capture_source_bit ? external_trigger_pin :
                    capture_input_pin[s_reg.input_source_select];
   assign sp_mode = (s_reg.ctrl.timer_mode_field == ptimer_pkg::MODE_PWM_PULSE) &&
                    (s_reg.ctrl.output_function_field == ptimer_pkg::OFN_PULSE);
   assign cap_mode = (s_reg.ctrl.timer_mode_field == ptimer_pkg::MODE_CAPTURE);
   assign run = s_reg.ctrl.counter_run_bit;
   assign run_rise = run & ~s_reg.run_prev;
   // Edges from second and third stages only
   assign trig_rise = s_reg.trig_sync[1] & ~s_reg.trig_sync[2];
   assign cap_rise = s_reg.cap_sync[1] & ~s_reg.cap_sync[2];
   assign cap_fall = ~s_reg.cap_sync[1] & s_reg.cap_sync[2];
   // Function field: 00 rise, 01 fall, 10 both, 11 none
   assign cap_hit = edge_hit(~s_reg.ctrl.output_function_field[0],
                             ^s_reg.ctrl.output_function_field,
                             cap_rise, cap_fall);
   // Clear field: 01 rise, 10 fall, 11 both, 00 none
   assign clr_hit = edge_hit(s_reg.ctrl.clear_trigger_field[0],
                             s_reg.ctrl.clear_trigger_field[1],
                             cap_rise, cap_fall);
   // Zero period lets the counter use its full range
   assign p_limit = (s_reg.period_compare == ptimer_pkg::CNT_ZERO) ? ptimer_pkg::CNT_MAX :
                    s_reg.period_compare;
   assign p_match = (s_reg.count == p_limit);
   assign a_match = (s_reg.count == s_reg.compare_capture_a);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Bus first, timer hardware afterwards so hardware wins a clash
   always_comb begin
      s_next = s_reg;
      s_next.evt = '0;
      // Two stage synchronisers plus an edge stage
      s_next.trig_sync = {s_reg.trig_sync[1:0], external_trigger_pin};
      s_next.cap_sync = {s_reg.cap_sync[1:0], cap_pin};
      // Write data phase commits the latched offset
      if (s_reg.wr_pend) begin
         case (s_reg.wr_addr)
            ptimer_pkg::OFS_CTRL: s_next.ctrl = ptimer_pkg::ctrl_s'(hwdata[ptimer_pkg::CTRL_W-1:0]);
            ptimer_pkg::OFS_INSEL: s_next.input_source_select = hwdata[ptimer_pkg::INSEL_LSB +: 2];
            // Low byte in bits 7:0, high byte bits in 9:8
            ptimer_pkg::OFS_CMP_CAP_A: begin
               s_next.compare_capture_a = hwdata[ptimer_pkg::CNT_W-1:0];
            end
            ptimer_pkg::OFS_CMP_CAP_B: begin
               s_next.compare_capture_b = hwdata[ptimer_pkg::CNT_W-1:0];
            end
            ptimer_pkg::OFS_PERIOD_CMP: begin
               s_next.period_compare = hwdata[ptimer_pkg::CNT_W-1:0];
            end
            default: s_next.wr_pend = 1'b0;
         endcase
      end
      // Address phase: latch writes, fetch reads
      s_next.wr_pend = bus_take & hwrite;
      if (bus_take) begin
         s_next.wr_addr = haddr[7:0];
      end
      if (bus_take & ~hwrite) begin
         s_next.rdata = read_word(s_reg, haddr[7:0]);
      end
      s_next.run_prev = run;
      // Timer counter
      if (run_rise) begin
         // Every start restarts the count from zero
         s_next.count = ptimer_pkg::CNT_ZERO;
      end else if (run && sp_mode) begin
         if (a_match) begin
            // Compare A ends the pulse and stops the count
            s_next.ctrl.counter_run_bit = 1'b0;
            s_next.evt.match_a = 1'b1;
         end else begin
            s_next.count = s_reg.count + ptimer_pkg::CNT_ONE;
         end
      end else if (run && cap_mode) begin
         // Store on the chosen edge; clear field 00 uses A only
         if (cap_hit) begin
            if ((s_reg.ctrl.clear_trigger_field == ptimer_pkg::TCLR_NONE) || cap_rise) begin
               s_next.compare_capture_a = s_reg.count;
            end else begin
               s_next.compare_capture_b = s_reg.count;
            end
            s_next.capture_level_flag = s_reg.cap_sync[1];
            s_next.evt.capture = 1'b1;
         end
         // Free run, cleared by period match or chosen edge
         if (p_match || clr_hit) begin
            s_next.count = ptimer_pkg::CNT_ZERO;
         end else begin
            s_next.count = s_reg.count + ptimer_pkg::CNT_ONE;
         end
         s_next.evt.match_p = p_match;
      end
      // Trigger pin edge sets the run bit, set beats any clear
      if (sp_mode && trig_rise) begin
         s_next.ctrl.counter_run_bit = 1'b1;
      end
      // Pulse edges: initial level at start, inverse once stopped
      if (sp_mode) begin
         if (run_rise) begin
            s_next.out_level = s_reg.ctrl.output_initial_state;
         end else if (!s_next.ctrl.counter_run_bit) begin
            s_next.out_level = ~s_reg.ctrl.output_initial_state;
         end
      end
      // Pin level and enable follow the next mode, none in capture
      s_next.out_pin = s_next.out_level ^ s_next.ctrl.output_polarity;
      s_next.drive = (s_next.ctrl.timer_mode_field == ptimer_pkg::MODE_PWM_PULSE) &&
                     (s_next.ctrl.output_function_field == ptimer_pkg::OFN_PULSE);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Constants only under reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.ctrl <= ptimer_pkg::CTRL_RST;
         s_reg.input_source_select <= ptimer_pkg::INSEL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = s_reg.rdata;
   assign hreadyout = 1'b1;                         // Zero wait states
   assign hresp = 1'b0;                             // Always OKAY
   assign timer_out = s_reg.out_pin;
   assign timer_out_en = s_reg.drive;
   assign timer_evt = s_reg.evt;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Single pulse start, then its first counting cycle
   sequence s_pulse_start;
      sp_mode && run_rise;
   endsequence
   sequence s_pulse_running;
      (s_reg.count == ptimer_pkg::CNT_ZERO) &&
      (s_reg.out_level == $past(s_reg.ctrl.output_initial_state));
   endsequence

   a_pulse_lead_edge: assert property (s_pulse_start |=> s_pulse_running)
      else $error("pulse start did not clear counter or set initial level");
   a_trigger_sets_run: assert property (sp_mode && trig_rise |=> run)
      else $error("trigger edge did not set run bit");
   a_match_a_stop: assert property (sp_mode && run && !run_rise && a_match && !trig_rise
      |=> !run && timer_evt.match_a)
      else $error("compare A match did not stop the pulse");
   a_pulse_trail: assert property (sp_mode && $past(sp_mode) && !run
      |-> s_reg.out_level != s_reg.ctrl.output_initial_state)
      else $error("stopped pulse output not at trailing level");
   a_capture_to_a: assert property (cap_mode && run && !run_rise && cap_hit &&
      s_reg.ctrl.clear_trigger_field == ptimer_pkg::TCLR_NONE
      |=> s_reg.compare_capture_a == $past(s_reg.count) && timer_evt.capture)
      else $error("capture did not store count in A");
   a_capture_none: assert property (cap_mode &&
      s_reg.ctrl.output_function_field == ptimer_pkg::EDGE_NONE |=> !timer_evt.capture)
      else $error("capture happened with edge select none");
   a_period_wrap: assert property (cap_mode && run && !run_rise && p_match
      |=> s_reg.count == ptimer_pkg::CNT_ZERO && timer_evt.match_p)
      else $error("period match did not clear counter");
   a_capture_free_run: assert property (cap_mode && run && !run_rise && !p_match && !clr_hit
      |=> s_reg.count == 10'($past(s_reg.count) + ptimer_pkg::CNT_ONE))
      else $error("capture counter did not advance");
   a_capture_no_drive: assert property (cap_mode |-> !timer_out_en)
      else $error("output driven in capture mode");
   a_edge_single: assert property (trig_rise |=> !trig_rise)
      else $error("trigger edge lasted more than one cycle");

endmodule : periodic_timer_pulse_capture

// file: sim/pin_source.sv
// Behavioural model of the trigger and capture signal sources on the pins
`timescale 1ns/100ps
module pin_source (
   // Clock
   input wire logic hclk,
   // Pins towards the timer
   output logic external_trigger_pin,
   output logic [3:0] capture_input_pin
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   initial begin
      external_trigger_pin = 1'b0;
      capture_input_pin = 4'h0;
   end
   // ----------------------------------------------------------------
   // Pulses, always at least two clocks wide so none is missed
   // ----------------------------------------------------------------
   // Trigger pin high for w cycles
   task automatic pulse_trig(input int w);
      external_trigger_pin <= 1'b1;
      repeat (w) @(posedge hclk);
      external_trigger_pin <= 1'b0;
   endtask : pulse_trig
   // One capture pin high for w cycles
   task automatic pulse_cap(input logic [1:0] i, input int w);
      capture_input_pin[i] <= 1'b1;
      repeat (w) @(posedge hclk);
      capture_input_pin[i] <= 1'b0;
   endtask : pulse_cap
endmodule : pin_source

// file: sim/periodic_timer_pulse_capture_test.sv
// Self-checking testbench of the periodic timer pulse and capture block
`timescale 1ns/100ps
module periodic_timer_pulse_capture_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic hclk, hresetn, hwrite, trig, tout, toe, hready, resp;
   logic [31:0] haddr, hwdata, hrdata, rd, t0;
   logic [1:0] htrans;
   logic [3:0] cap;
   ptimer_pkg::timer_evt_s evt;
   int n_errors = 0, n_checks = 0, n_cap = 0, n_a = 0, n_p = 0, n_hi = 0;
   // Design and pin sources
   periodic_timer_pulse_capture u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(resp),
      .external_trigger_pin(trig), .capture_input_pin(cap), .timer_out(tout),
      .timer_out_en(toe), .timer_evt(evt));
   pin_source u_src (.hclk(hclk), .external_trigger_pin(trig), .capture_input_pin(cap));
   // ----------------------------------------------------------------
   // Clock, event counters, watchdog
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Count event pulses and pulse-high cycles
   always @(posedge hclk) begin
      if (evt.capture === 1'b1) n_cap++;
      if (evt.match_a === 1'b1) n_a++;
      if (evt.match_p === 1'b1) n_p++;
      if (tout === 1'b1) n_hi++;
   end
   // Cut a hang short
   initial begin
      repeat (5000) @(posedge hclk);
      n_errors++;
      end_sim();
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : chk
   // One bus transfer, address then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= ptimer_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rdchk
   // Closeness test for timing-dependent values
   function automatic logic near(input logic [31:0] v, input int e, input int tol);
      return (int'(v) >= e - tol) && (int'(v) <= e + tol);
   endfunction : near
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, read-only and unmapped places
      rdchk(ptimer_pkg::OFS_CTRL, 32'h0, "ctrl reset");
      chk(resp, 1'b0, "okay response");
      wr(ptimer_pkg::OFS_COUNT, 32'h155);
      rdchk(ptimer_pkg::OFS_COUNT, 32'h0, "count read only");
      wr(8'h1C, 32'hFFFF);
      rdchk(8'h1C, 32'h0, "unmapped");
      wr(ptimer_pkg::OFS_CMP_CAP_B, 32'hFFFF_FFFF);
      rdchk(ptimer_pkg::OFS_CMP_CAP_B, 32'h3FF, "ten bit reg");
      $display("test regs done");
      // Software-started pulse, period register and clear select ignored
      wr(ptimer_pkg::OFS_CMP_CAP_A, 32'h5);
      wr(ptimer_pkg::OFS_PERIOD_CMP, 32'h2);
      n_hi = 0;
      n_p = 0;
      wr(ptimer_pkg::OFS_CTRL, 32'hDE);
      // Second edge: outputs launched at the first are settled here
      repeat (2) @(posedge hclk);
      chk(toe, 1'b1, "pulse drive");
      chk(tout, 1'b1, "leading edge");
      repeat (12) @(posedge hclk);
      chk(n_a, 1, "match a event");
      chk(near(n_hi, 6, 1), 1'b1, "pulse width");
      chk(n_p, 0, "period unused");
      rdchk(ptimer_pkg::OFS_CTRL, 32'h5E, "run cleared");
      xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0);
      t0 = rd;
      rdchk(ptimer_pkg::OFS_COUNT, t0, "count held");
      $display("test soft pulse done");
      // Pin-started pulse, cut short by software
      wr(ptimer_pkg::OFS_CMP_CAP_A, 32'h3FF);
      wr(ptimer_pkg::OFS_CTRL, 32'h1E);
      n_hi = 0;
      u_src.pulse_trig(3);
      repeat (4) @(posedge hclk);
      rdchk(ptimer_pkg::OFS_CTRL, 32'h9E, "pin sets run");
      xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0);
      chk(near(rd, 5, 2), 1'b1, "counter runs from zero");
      wr(ptimer_pkg::OFS_CTRL, 32'h1E);
      @(posedge hclk);
      chk(tout, 1'b0, "trailing edge");
      chk(near(n_hi, 9, 2), 1'b1, "pin pulse width");
      $display("test pin pulse done");
      // Rising-edge capture into register A, free running count
      wr(ptimer_pkg::OFS_PERIOD_CMP, 32'h0);
      wr(ptimer_pkg::OFS_CTRL, 32'h81);
      repeat (20) @(posedge hclk);
      n_cap = 0;
      u_src.pulse_cap(2'h0, 4);
      repeat (10) @(posedge hclk);
      chk(toe, 1'b0, "capture no drive");
      chk(n_cap, 1, "one capture per edge");
      xfer(1'b0, ptimer_pkg::OFS_CMP_CAP_A, 32'h0);
      chk(near(rd, 21, 3), 1'b1, "captured count");
      // Pin was high after the captured rising edge
      rdchk(ptimer_pkg::OFS_STAT, 32'h1, "level flag");
      // No edge selected: counter still runs
      wr(ptimer_pkg::OFS_CTRL, 32'h8D);
      u_src.pulse_cap(2'h0, 4);
      repeat (8) @(posedge hclk);
      chk(n_cap, 1, "no capture when none");
      xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0);
      chk(near(rd, 51, 3), 1'b1, "counter free runs");
      $display("test capture a done");
      // Period match clears count
      wr(ptimer_pkg::OFS_CTRL, 32'h0);
      wr(ptimer_pkg::OFS_PERIOD_CMP, 32'hA);
      n_p = 0;
      wr(ptimer_pkg::OFS_CTRL, 32'h81);
      repeat (40) @(posedge hclk);
      chk(near(n_p, 3, 0), 1'b1, "period events");
      $display("test period done");
      // Rising edge clears, falling edge captures into B, pin 2
      wr(ptimer_pkg::OFS_CTRL, 32'h0);
      wr(ptimer_pkg::OFS_PERIOD_CMP, 32'h0);
      wr(ptimer_pkg::OFS_CMP_CAP_A, 32'h0);
      wr(ptimer_pkg::OFS_INSEL, 32'h80);
      wr(ptimer_pkg::OFS_CTRL, 32'h185);
      repeat (30) @(posedge hclk);
      u_src.pulse_cap(2'h2, 8);
      repeat (6) @(posedge hclk);
      xfer(1'b0, ptimer_pkg::OFS_CMP_CAP_B, 32'h0);
      chk(near(rd, 8, 2), 1'b1, "width into b");
      rdchk(ptimer_pkg::OFS_CMP_CAP_A, 32'h0, "a untouched by fall");
      // Trigger pin as capture source
      wr(ptimer_pkg::OFS_CTRL, 32'h481);
      n_cap = 0;
      u_src.pulse_trig(3);
      repeat (6) @(posedge hclk);
      chk(n_cap, 1, "trigger pin capture");
      $display("test capture b done");
      end_sim();
   end
endmodule : periodic_timer_pulse_capture_test
